// ### verilog/eif_pkg.sv
// Constants and carrier types for the external interrupt flag and type control.
// Assumes an APB slave with 32-bit data; all offsets are byte addresses.
package eif_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] CTRL_OFF   = 8'h00; // Control: types and pending flags
	localparam logic [7:0] POL_OFF    = 8'h04; // Polarity select per channel
	localparam logic [7:0] STAT_OFF   = 8'h08; // Sticky event status, write one to clear
	localparam logic [7:0] MASK_OFF   = 8'h0C; // Interrupt mask, same layout as status
	localparam logic [7:0] VECT_OFF   = 8'h10; // Vector acknowledge strobe, write only
	// ==========================================================
	// Field positions in the control register
	localparam int TYPE_A_BIT = 0; // Channel 0 trigger type
	localparam int PEND_A_BIT = 1; // Channel 0 pending flag
	localparam int TYPE_B_BIT = 2; // Channel 1 trigger type
	localparam int PEND_B_BIT = 3; // Channel 1 pending flag
	// Polarity, status, mask and vector: bit 0 channel 0, bit 1 channel 1
	localparam int CH_A_BIT   = 0;
	localparam int CH_B_BIT   = 1;
	// ==========================================================
	// Reset values
	localparam logic [1:0] TYPE_RST = 2'h0;
	localparam logic [1:0] POL_RST  = 2'h0; // Zero selects active low
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [31:0] ERR_DATA = 32'h0000_0000;

	// One channel's configuration
	typedef struct packed {
		logic edge_mode; // 1 edge, 0 level
		logic act_high;  // 1 active high
	} eif_cfg_t;

	// Decoded APB write request
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [31:0] data;
	} eif_wreq_t;
endpackage

// ### verilog/eif_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes input comes from a pin outside the CLK domain.
`timescale 1ns/1ps
`default_nettype none
module eif_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta_r;
	logic meta_nxt;
	logic sync_nxt;

	// ==========================================================
	// Next values; first stage feeds only the second
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// Registers, reset to inactive-high idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_r   <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end
endmodule
`default_nettype wire

// ### verilog/eif_chan.sv
// One channel of external interrupt detection and pending flag.
// Assumes a synchronised pin level and single-cycle clear strobes.
`timescale 1ns/1ps
`default_nettype none
module eif_chan (
	input  wire logic            clk,
	input  wire logic            rst_b,
	input  wire logic            pin_sync,
	input  wire eif_pkg::eif_cfg_t cfg,
	input  wire logic            sw_clr,
	input  wire logic            vect_ack,
	output var  logic            pend,
	output var  logic            event_p
);
	logic act_r;
	logic act_nxt;
	logic pend_nxt;
	logic active;
	logic rise;

	// ==========================================================
	// Active level from polarity, rising edge of activity
	always_comb begin
		active   = cfg.act_high ? pin_sync : ~pin_sync;
		act_nxt  = active;
		rise     = active & ~act_r;
		pend_nxt = pend;
		event_p  = 1'b0;
		if (cfg.edge_mode) begin
			if (sw_clr || vect_ack) begin
				pend_nxt = 1'b0;
			end
			if (rise) begin
				pend_nxt = 1'b1; // Set beats clear
				event_p  = 1'b1;
			end
		end else begin
			// Level mode tracks the input, so a clear only lasts while inactive
			pend_nxt = active;
			event_p  = rise;
		end
	end

	// Registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_r <= 1'b0;
			pend  <= 1'b0;
		end else begin
			act_r <= act_nxt;
			pend  <= pend_nxt;
		end
	end
endmodule
`default_nettype wire

// ### verilog/eif_top.sv
// Top of the external interrupt flag and trigger-type control, APB slave.
// Assumes two async interrupt pins and a vector acknowledge pulse per channel from the CPU side.
// Notes on behaviour
// - Channel 1 pending flag is set on the edge or level chosen by its type bit.
// - In edge mode software may clear channel 1 flag, and vectoring clears it too.
// - In level mode channel 1 flag is one while its input is at the active level.
// - Channel 1 active level comes from its polarity select bit.
// - Channel 0 pending flag is set on the edge or level chosen by its type bit.
// - In edge mode software may clear channel 0 flag, and vectoring clears it too.
// - In level mode channel 0 flag is one while its input is at the active level.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module eif_top (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        EXT_IRQ_IN_A,
	input  wire logic        EXT_IRQ_IN_B,
	input  wire logic        VECT_A,
	input  wire logic        VECT_B,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output var  logic        PREADY,
	output var  logic        PSLVERR,
	output var  logic        IRQ,
	output var  logic        PEND_A,
	output var  logic        PEND_B
);
	logic        rst_m_r;
	logic        rst_b_r;
	logic        pin_a_s;
	logic        pin_b_s;
	logic [1:0]  type_r;
	logic [1:0]  type_nxt;
	logic [1:0]  pol_r;
	logic [1:0]  pol_nxt;
	logic [1:0]  stat_r;
	logic [1:0]  stat_nxt;
	logic [1:0]  mask_r;
	logic [1:0]  mask_nxt;
	logic [31:0] rdata_nxt;
	logic        ready_nxt;
	logic        err_nxt;
	logic        irq_nxt;
	logic        pend_a;
	logic        pend_b;
	logic        ev_a;
	logic        ev_b;
	logic        clr_a;
	logic        clr_b;
	logic        vect_a_s;
	logic        vect_b_s;
	logic        acc;
	eif_pkg::eif_wreq_t  wreq;
	eif_pkg::eif_cfg_t   cfg_a;
	eif_pkg::eif_cfg_t   cfg_b;

	// Address decode for the error answer; every mapped slot is one aligned word
	function automatic logic map_hit(input logic [7:0] addr);
		map_hit = (addr == eif_pkg::CTRL_OFF) || (addr == eif_pkg::POL_OFF)
			|| (addr == eif_pkg::STAT_OFF) || (addr == eif_pkg::MASK_OFF)
			|| (addr == eif_pkg::VECT_OFF);
	endfunction

	// ==========================================================
	// Reset release through two flops
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_m_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_b_r <= rst_m_r;
		end
	end

	// ==========================================================
	// Pin synchronisers
	eif_sync u_sync_a (
		.clk      (CLK),
		.rst_b    (rst_b_r),
		.async_in (EXT_IRQ_IN_A),
		.sync_out (pin_a_s)
	);
	eif_sync u_sync_b (
		.clk      (CLK),
		.rst_b    (rst_b_r),
		.async_in (EXT_IRQ_IN_B),
		.sync_out (pin_b_s)
	);

	// ==========================================================
	// Bus decode; ready rises one cycle into the access phase
	// A write commits only at the edge where the master samples that ready
	always_comb begin
		acc       = PSEL & PENABLE & ~PREADY;
		wreq.wr   = PSEL & PENABLE & PREADY & PWRITE;
		wreq.addr = PADDR;
		wreq.data = PWDATA;
	end

	// Write-zero-to-clear of pending flags via control reg, vector strobes
	always_comb begin
		clr_a    = 1'b0;
		clr_b    = 1'b0;
		vect_a_s = VECT_A;
		vect_b_s = VECT_B;
		if (wreq.wr && wreq.addr == eif_pkg::CTRL_OFF) begin
			// Writing zero to a pending bit clears it, as with the original flag
			clr_a = ~wreq.data[eif_pkg::PEND_A_BIT];
			clr_b = ~wreq.data[eif_pkg::PEND_B_BIT];
		end else if (wreq.wr && wreq.addr == eif_pkg::VECT_OFF) begin
			vect_a_s = VECT_A | wreq.data[eif_pkg::CH_A_BIT];
			vect_b_s = VECT_B | wreq.data[eif_pkg::CH_B_BIT];
		end
	end

	// Channel configs; polarity and type select
	always_comb begin
		cfg_a.edge_mode = type_r[eif_pkg::CH_A_BIT];
		cfg_a.act_high  = pol_r[eif_pkg::CH_A_BIT];
		cfg_b.edge_mode = type_r[eif_pkg::CH_B_BIT];
		cfg_b.act_high  = pol_r[eif_pkg::CH_B_BIT];
	end

	// ==========================================================
	// channel 0 and channel 1 flags
	eif_chan u_chan_a (
		.clk      (CLK),
		.rst_b    (rst_b_r),
		.pin_sync (pin_a_s),
		.cfg      (cfg_a),
		.sw_clr   (clr_a),
		.vect_ack (vect_a_s),
		.pend     (pend_a),
		.event_p  (ev_a)
	);
	eif_chan u_chan_b (
		.clk      (CLK),
		.rst_b    (rst_b_r),
		.pin_sync (pin_b_s),
		.cfg      (cfg_b),
		.sw_clr   (clr_b),
		.vect_ack (vect_b_s),
		.pend     (pend_b),
		.event_p  (ev_b)
	);

	// ==========================================================
	// Register next values and read mux
	always_comb begin
		type_nxt  = type_r;
		pol_nxt   = pol_r;
		mask_nxt  = mask_r;
		stat_nxt  = stat_r;
		rdata_nxt = PRDATA;
		ready_nxt = acc;
		err_nxt   = 1'b0;
		// Write one clears status
		if (wreq.wr && wreq.addr == eif_pkg::STAT_OFF) begin
			stat_nxt = stat_r & ~wreq.data[1:0];
		end
		// Events set after clear so set wins
		stat_nxt = stat_nxt | {ev_b, ev_a};
		if (wreq.wr) begin
			if (wreq.addr == eif_pkg::CTRL_OFF) begin
				type_nxt[eif_pkg::CH_A_BIT] = wreq.data[eif_pkg::TYPE_A_BIT];
				type_nxt[eif_pkg::CH_B_BIT] = wreq.data[eif_pkg::TYPE_B_BIT];
			end else if (wreq.addr == eif_pkg::POL_OFF) begin
				pol_nxt = wreq.data[1:0];
			end else if (wreq.addr == eif_pkg::MASK_OFF) begin
				mask_nxt = wreq.data[1:0];
			end
		end
		// Unmapped slots answer with an error in either direction
		if (acc && !map_hit(wreq.addr)) begin
			err_nxt = 1'b1;
		end
		// Read data settles with ready and holds until the next read
		if (acc && !PWRITE) begin
			rdata_nxt = eif_pkg::ERR_DATA;
			if (wreq.addr == eif_pkg::CTRL_OFF) begin
				rdata_nxt[eif_pkg::TYPE_A_BIT] = type_r[eif_pkg::CH_A_BIT];
				rdata_nxt[eif_pkg::PEND_A_BIT] = pend_a;
				rdata_nxt[eif_pkg::TYPE_B_BIT] = type_r[eif_pkg::CH_B_BIT];
				rdata_nxt[eif_pkg::PEND_B_BIT] = pend_b;
			end else if (wreq.addr == eif_pkg::POL_OFF) begin
				rdata_nxt[1:0] = pol_r;
			end else if (wreq.addr == eif_pkg::STAT_OFF) begin
				rdata_nxt[1:0] = stat_r;
			end else if (wreq.addr == eif_pkg::MASK_OFF) begin
				rdata_nxt[1:0] = mask_r;
			end else if (wreq.addr == eif_pkg::VECT_OFF) begin
				rdata_nxt = eif_pkg::ERR_DATA; // Write only, reads zero
			end else begin
				err_nxt = 1'b1;
			end
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	// Registers of the slave and outputs
	always_ff @(posedge CLK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			type_r  <= eif_pkg::TYPE_RST;
			pol_r   <= eif_pkg::POL_RST;
			mask_r  <= eif_pkg::MASK_RST;
			stat_r  <= 2'h0;
			PRDATA  <= eif_pkg::ERR_DATA;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			IRQ     <= 1'b0;
			PEND_A  <= 1'b0;
			PEND_B  <= 1'b0;
		end else begin
			type_r  <= type_nxt;
			pol_r   <= pol_nxt;
			mask_r  <= mask_nxt;
			stat_r  <= stat_nxt;
			PRDATA  <= rdata_nxt;
			PREADY  <= ready_nxt;
			PSLVERR <= err_nxt;
			IRQ     <= irq_nxt;
			PEND_A  <= pend_a;
			PEND_B  <= pend_b;
		end
	end
endmodule
`default_nettype wire

// ### tb/eif_chk.sv
// Port checker for eif_top: bus timing, level follow, edge set, vector clear.
// Assumes binding to eif_top; configuration is shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
module eif_chk (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        EXT_IRQ_IN_A,
	input wire logic        EXT_IRQ_IN_B,
	input wire logic        VECT_A,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        IRQ,
	input wire logic        PEND_A,
	input wire logic        PEND_B
);
	// Shadow {mask, pol, type b, type a}; updates at the completing edge of a write
	logic [5:0] cfg_r;
	logic [5:0] cfg_nxt;
	logic       bad;
	always_comb begin
		cfg_nxt = cfg_r;
		bad = !(PADDR inside {eif_pkg::CTRL_OFF, eif_pkg::POL_OFF,
			eif_pkg::STAT_OFF, eif_pkg::MASK_OFF, eif_pkg::VECT_OFF});
		if (PSEL && PENABLE && PREADY && PWRITE) begin
			case (PADDR)
				eif_pkg::CTRL_OFF: cfg_nxt[1:0] = {PWDATA[2], PWDATA[0]};
				eif_pkg::POL_OFF:  cfg_nxt[3:2] = PWDATA[1:0];
				eif_pkg::MASK_OFF: cfg_nxt[5:4] = PWDATA[1:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			cfg_r <= 6'h00;
		else
			cfg_r <= cfg_nxt;
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wait_one_a: assert property ($rose(PENABLE) && PSEL |=> PREADY)
		else $error("ready not one cycle after access");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	err_map_a: assert property (PREADY |-> PSLVERR == bad)
		else $error("error flag disagrees with map");
	lvl_a_a: assert property (
		(!cfg_r[0] && !PSEL && $stable(cfg_r) && $stable(EXT_IRQ_IN_A))[*8]
		|-> PEND_A == (EXT_IRQ_IN_A == cfg_r[2])) else $error("ch0 level flag");
	lvl_b_a: assert property (
		(!cfg_r[1] && !PSEL && $stable(cfg_r) && $stable(EXT_IRQ_IN_B))[*8]
		|-> PEND_B == (EXT_IRQ_IN_B == cfg_r[3])) else $error("ch1 level flag");
	edge_b_a: assert property (
		cfg_r[1] && $changed(EXT_IRQ_IN_B) && EXT_IRQ_IN_B == cfg_r[3]
		|-> ##[2:4] PEND_B) else $error("ch1 edge not flagged");
	vect_a_a: assert property (
		(cfg_r[0] && $stable(EXT_IRQ_IN_A))[*5] ##0 VECT_A |-> ##2 !PEND_A)
		else $error("ch0 vector clear missing");
	irq_off_a: assert property ((cfg_r[5:4] == 2'h0)[*3] |-> !IRQ)
		else $error("irq with all masked");
	cover property (PREADY && PSLVERR);
	cover property (IRQ);
	cover property (VECT_A && PEND_A);
endmodule
bind eif_top eif_chk eif_chk_inst (.CLK, .RST_B, .EXT_IRQ_IN_A, .EXT_IRQ_IN_B, .VECT_A,
	.PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .IRQ, .PEND_A, .PEND_B);
`default_nettype wire

// ### tb/eif_pin_model.sv
// Interrupt pins and CPU vectoring on the far side of eif_top.
// Assumes the bench calls vector just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module eif_pin_model (
	input  wire logic clk,
	input  wire logic lvl_a,
	input  wire logic lvl_b,
	output var  logic pin_a,
	output var  logic pin_b,
	output var  logic vect_a,
	output var  logic vect_b
);
	// Pins always driven; no pull, so no floating level to model
	assign pin_a = lvl_a;
	assign pin_b = lvl_b;
	initial {vect_a, vect_b} = 2'h0;
	// One-cycle entry into a routine, as the CPU does
	task automatic vector(input logic b);
		if (b)
			vect_b <= 1'b1;
		else
			vect_a <= 1'b1;
		@(posedge clk);
		{vect_a, vect_b} <= 2'h0;
	endtask
endmodule
`default_nettype wire

// ### tb/eif_top_tb.sv
// Self-checking bench for eif_top with the pin model.
// Assumes a 4 ns clock; pins settle well inside eight cycles.
`timescale 1ns/1ps
`default_nettype none
module eif_top_tb;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic e;} eif_row_t;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
	logic        pend_a, pend_b, lvl_a, lvl_b, pin_a, pin_b, vect_a, vect_b;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          failures, checks_done, cyc;
	// Reset values, round trips, unmapped slot
	localparam eif_row_t ROWS [12] = '{
		{1'b0, eif_pkg::CTRL_OFF, 32'h0, 1'b0}, {1'b0, eif_pkg::POL_OFF, 32'h0, 1'b0},
		{1'b0, eif_pkg::STAT_OFF, 32'h0, 1'b0}, {1'b0, eif_pkg::MASK_OFF, 32'h0, 1'b0},
		{1'b1, eif_pkg::POL_OFF, 32'h3, 1'b0}, {1'b0, eif_pkg::POL_OFF, 32'h3, 1'b0},
		{1'b1, eif_pkg::MASK_OFF, 32'h3, 1'b0}, {1'b0, eif_pkg::MASK_OFF, 32'h3, 1'b0},
		{1'b1, eif_pkg::MASK_OFF, 32'h0, 1'b0}, {1'b1, 8'h14, 32'hFF, 1'b1},
		{1'b0, 8'h14, 32'h0, 1'b1}, {1'b1, eif_pkg::POL_OFF, 32'h0, 1'b0}};
	always #2 clk = ~clk;
	eif_top eif_top_inst (.CLK(clk), .RST_B(rst_b), .EXT_IRQ_IN_A(pin_a),
		.EXT_IRQ_IN_B(pin_b), .VECT_A(vect_a), .VECT_B(vect_b), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
		.PEND_A(pend_a), .PEND_B(pend_b));
	eif_pin_model eif_pin_model_inst (.clk, .lvl_a, .lvl_b, .pin_a, .pin_b, .vect_a,
		.vect_b);
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; waits for the answer, never a fixed count
	task automatic op(input eif_row_t r);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, r.w, r.a, r.d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		chk("slverr", r.e, pslverr);
		if (!r.w)
			chk("rdata", r.d, rd);
		{psel, penable} <= 2'h0;
	endtask
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, far above the expected few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		{clk, rst_b, psel, penable, pwrite, lvl_a, lvl_b, paddr, pwdata} = 47'h3 << 40;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (ROWS[i]) op(ROWS[i]);
		lvl_a <= 1'b0;
		settle();
		chk("pend_a", 1, pend_a);
		op({1'b0, eif_pkg::CTRL_OFF, 32'h2, 1'b0});
		lvl_a <= 1'b1;
		settle();
		chk("pend_a", 0, pend_a);
		op({1'b1, eif_pkg::POL_OFF, 32'h2, 1'b0});
		settle();
		chk("pend_b", 1, pend_b);
		lvl_b <= 1'b0;
		settle();
		chk("pend_b", 0, pend_b);
		op({1'b1, eif_pkg::POL_OFF, 32'h0, 1'b0});
		op({1'b1, eif_pkg::CTRL_OFF, 32'h5, 1'b0});
		// First write still ran under level type, so its clear did not last
		op({1'b1, eif_pkg::CTRL_OFF, 32'h5, 1'b0});
		settle();
		chk("pend_b", 0, pend_b);
		lvl_b <= 1'b1;
		settle();
		lvl_b <= 1'b0;
		settle();
		lvl_b <= 1'b1;
		settle();
		chk("pend_b", 1, pend_b);
		op({1'b1, eif_pkg::CTRL_OFF, 32'h5, 1'b0});
		settle();
		chk("pend_b", 0, pend_b);
		// Channel 1 vector clear, by the CPU strobe and by the vector slot
		lvl_b <= 1'b0;
		settle();
		chk("pend_b", 1, pend_b);
		eif_pin_model_inst.vector(1'b1);
		settle();
		chk("pend_b", 0, pend_b);
		lvl_b <= 1'b1;
		settle();
		lvl_b <= 1'b0;
		settle();
		chk("pend_b", 1, pend_b);
		op({1'b1, eif_pkg::VECT_OFF, 32'h2, 1'b0});
		settle();
		chk("pend_b", 0, pend_b);
		lvl_b <= 1'b1;
		settle();
		lvl_a <= 1'b0;
		settle();
		chk("pend_a", 1, pend_a);
		eif_pin_model_inst.vector(1'b0);
		settle();
		chk("pend_a", 0, pend_a);
		op({1'b1, eif_pkg::CTRL_OFF, 32'h4, 1'b0});
		settle();
		eif_pin_model_inst.vector(1'b0);
		settle();
		chk("pend_a", 1, pend_a);
		lvl_a <= 1'b1;
		settle();
		op({1'b1, eif_pkg::STAT_OFF, 32'h3, 1'b0});
		op({1'b0, eif_pkg::STAT_OFF, 32'h0, 1'b0});
		op({1'b1, eif_pkg::MASK_OFF, 32'h1, 1'b0});
		lvl_a <= 1'b0;
		settle();
		chk("irq", 1, irq);
		op({1'b1, eif_pkg::MASK_OFF, 32'h0, 1'b0});
		settle();
		chk("irq", 0, irq);
		op({1'b1, eif_pkg::STAT_OFF, 32'h1, 1'b0});
		op({1'b0, eif_pkg::STAT_OFF, 32'h0, 1'b0});
		rst_b <= 1'b0;
		settle();
		chk("pend_a", 0, pend_a);
		rst_b <= 1'b1;
		settle();
		chk("pend_a", 1, pend_a);
		tally_and_finish();
	end
endmodule
`default_nettype wire
